// *** dma_pkg.sv ***
// shared constants, register map and types for the two channel dma unit
package dma_pkg;

    localparam int unsigned ADDR_W = 20;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned REG_AW = 4;

    // register map, per channel base = ch * CH_STRIDE
    localparam logic [REG_AW-1:0] CH_STRIDE   = 4'h8;
    localparam logic [REG_AW-1:0] OFF_SRC_LO  = 4'h0;
    localparam logic [REG_AW-1:0] OFF_SRC_HI  = 4'h1;
    localparam logic [REG_AW-1:0] OFF_DST_LO  = 4'h2;
    localparam logic [REG_AW-1:0] OFF_DST_HI  = 4'h3;
    localparam logic [REG_AW-1:0] OFF_COUNT   = 4'h4;
    localparam logic [REG_AW-1:0] OFF_CTRL    = 4'h5;
    localparam logic [REG_AW-1:0] OFF_STATUS  = 4'h6;

    // control register field positions
    localparam int unsigned B_DST_MEM  = 15;
    localparam int unsigned B_DST_DEC  = 14;
    localparam int unsigned B_DST_INC  = 13;
    localparam int unsigned B_SRC_MEM  = 12;
    localparam int unsigned B_SRC_DEC  = 11;
    localparam int unsigned B_SRC_INC  = 10;
    localparam int unsigned B_TERM_TC  = 9;
    localparam int unsigned B_INT_EN   = 8;
    localparam int unsigned B_SYNC_HI  = 7;
    localparam int unsigned B_SYNC_LO  = 6;
    localparam int unsigned B_PRIO_HI  = 5;
    localparam int unsigned B_TIMER_RQ = 4;
    localparam int unsigned B_SUSPEND  = 3;
    localparam int unsigned B_CHANGE   = 2;
    localparam int unsigned B_ARM      = 1;
    localparam int unsigned B_WORD     = 0;

    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // synchronisation modes
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_SRC  = 2'h1;
    localparam logic [1:0] SYNC_DST  = 2'h2;

    // pin samples skipped after a fetch, in falling clock output edges
    localparam int unsigned PIN_BLANK = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              io_space;
        logic              word;
        logic              write;
    } bus_req_t;

endpackage

// *** dma_req_sync.sv ***
// two flop synchroniser sampled on falling clock output edge
`timescale 1ns/100ps
module dma_req_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // falling clock output edge enable
    input  wire logic fall_en,
    // raw pin and synchronised level
    input  wire logic pin,
    output logic      level
);

    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            level  <= 1'b0;
        end else if (fall_en) begin
            meta_q <= pin;
            level  <= meta_q;
        end
    end

endmodule

// *** dma_arbiter.sv ***
// two channel priority arbiter with fixed and rotating modes
`timescale 1ns/100ps
module dma_arbiter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // channel requests and priorities
    input  wire logic [1:0] req,
    input  wire logic [1:0] prio_hi,
    // arbitration update
    input  wire logic       take,
    input  wire logic       done_ch,
    input  wire logic       bus_release,
    // winner
    output logic            grant_ch,
    output logic            grant_valid
);

    // rotation pointer: 1 means channel 1 has precedence
    logic favour_one_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            favour_one_q <= 1'b1; // R25
        end else if (bus_release) begin
            favour_one_q <= 1'b1; // R26
        end else if (take) begin
            favour_one_q <= ~done_ch; // R25
        end
    end

    always_comb begin
        grant_valid = |req;
        if (req == 2'b01) begin
            grant_ch = 1'b0;
        end else if (req == 2'b10) begin
            grant_ch = 1'b1;
        end else if (prio_hi[0] != prio_hi[1]) begin
            grant_ch = prio_hi[1]; // R24
        end else begin
            grant_ch = favour_one_q; // R22
        end
    end

endmodule

// *** dma_unit.sv ***
// two channel dma unit: registers, request logic, transfer sequencer
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
//
// Behaviour
// R1: twenty-bit linear source and destination pointers
// R2: io cycles run at any pointer value
// R3: pointers step up, down or hold
// R4: requests ignored until channel armed
// R5: pin sampled falling edge, four clocks
// R6: latched request cleared four clocks early
// R7: peripheral drops request by deposit start
// R8: source gets three clocks to drop
// R9: destination sync appends two idle states
// R10: bus released during appended idle states
// R11: one transfer per timer maximum count
// R12: unsynchronised runs back to back
// R13: sixteen-bit count decrements once per transfer
// R14: terminate on count disarms channel
// R15: unsynchronised always terminates at zero
// R16: disarm finishes current transfer first
// R17: nmi inhibits transfers until return
// R18: suspend holds channel without disarming
// R19: interrupt request at count zero
// R20: pending request signalled to bus unit
// R21: no chip select above 64K io
// R22: equal priorities rotate precedence
// R23: fetch then deposit, never split
// R24: high priority preempts low channel
// R25: channel 1 starts first, then rotates
// R26: channel 1 regains precedence on release
// R27: one pending request, held until done
module dma_unit #(
    parameter int unsigned N_CH = 2
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // register port
    input  wire logic [dma_pkg::REG_AW:0]   reg_addr,
    input  wire logic [15:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [15:0]                reg_rdata,
    // request sources
    input  wire logic [1:0]                 dma_request_pin,
    input  wire logic                       clock_output_pin,
    input  wire logic                       timer_max,
    input  wire logic                       nmi_active,
    input  wire logic                       nmi_return,
    // bus interface unit handshake
    output logic                            biu_req,
    input  wire logic                       biu_gnt,
    input  wire logic                       biu_done,
    output dma_pkg::bus_req_t               biu_cmd,
    output logic                            bus_master_status_bit,
    output logic                            cs_allow,
    input  wire logic [15:0]                biu_rdata,
    output logic      [15:0]                biu_wdata,
    // interrupt requests
    output logic [1:0]                      tc_irq
);

    if (N_CH != 2) begin : g_bad_n_ch
        $error("dma_unit supports two channels only");
    end

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_FETCH   = 5'b00010,
        ST_DEPOSIT = 5'b00100,
        ST_IDLE1   = 5'b01000,
        ST_IDLE2   = 5'b10000
    } seq_t;

    ////////////////////////////////////////
    // channel state

    logic [dma_pkg::ADDR_W-1:0] src_q  [2];
    logic [dma_pkg::ADDR_W-1:0] dst_q  [2];
    logic [dma_pkg::CNT_W-1:0]  cnt_q  [2];
    logic [15:0]                ctrl_q [2];
    logic [1:0]                 pin_lvl;
    logic [1:0]                 ext_latch_q;
    logic [1:0]                 timer_pend_q;
    logic [1:0]                 req_ok;
    logic [1:0]                 tc_hit_q;
    logic                       nmi_block_q;
    logic                       clk_out_s1_q;
    logic                       clk_out_s2_q;
    logic                       clk_out_d_q;
    logic                       fall_en;
    seq_t                       st_q;
    logic                       ch_q;
    logic [15:0]                hold_q;
    logic                       nmi_prev_q;
    logic                       grant_ch;
    logic                       grant_valid;
    logic                       take;
    logic                       xfer_end;
    logic                       release_bus;
    logic [dma_pkg::ADDR_W-1:0] cur_addr;
    logic                       cur_io;

    ////////////////////////////////////////
    // falling clock output edge detect, after two flops

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_out_s1_q <= 1'b0;
            clk_out_s2_q <= 1'b0;
            clk_out_d_q  <= 1'b0;
            nmi_prev_q   <= 1'b0;
        end else begin
            clk_out_s1_q <= clock_output_pin;
            clk_out_s2_q <= clk_out_s1_q;
            clk_out_d_q  <= clk_out_s2_q;
            nmi_prev_q   <= nmi_active;
        end
    end

    assign fall_en = clk_out_d_q & ~clk_out_s2_q; // R5

    ////////////////////////////////////////
    // nmi suspension, set on entry so software may re-enable

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_block_q <= 1'b0;
        end else if (reg_wr && reg_addr == {1'b0, dma_pkg::OFF_STATUS}
                     && reg_wdata[0]) begin
            nmi_block_q <= 1'b0; // R17
        end else if (nmi_active && !nmi_prev_q) begin
            nmi_block_q <= 1'b1; // R17
        end else if (nmi_return) begin
            nmi_block_q <= 1'b0; // R17
        end
    end

    ////////////////////////////////////////
    // per channel registers and request logic

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [dma_pkg::REG_AW:0] base;
        logic [1:0]               sync;
        logic                     active;
        logic                     done_now;
        logic                     last;
        logic                     stop_now;
        logic [dma_pkg::ADDR_W-1:0] step;
        logic [1:0]                 blank_q;

        assign base     = c[0] ? {1'b0, dma_pkg::CH_STRIDE} : '0;
        assign sync     = ctrl_q[c][dma_pkg::B_SYNC_HI:dma_pkg::B_SYNC_LO];
        assign active   = st_q != ST_IDLE && ch_q == c[0];
        assign done_now = active && st_q == ST_DEPOSIT && biu_done;
        assign last     = cnt_q[c] == {{(dma_pkg::CNT_W-1){1'b0}}, 1'b1};
        assign stop_now = done_now && last && (ctrl_q[c][dma_pkg::B_TERM_TC]
                          || sync == dma_pkg::SYNC_NONE); // R14 R15
        assign step     = ctrl_q[c][dma_pkg::B_WORD] ? 20'h00002 : 20'h00001; // R3

        dma_req_sync u_sync (
            .clk     (clk),
            .rst_n   (rst_n),
            .fall_en (fall_en),
            .pin     (dma_request_pin[c]),
            .level   (pin_lvl[c])
        );

        // latched external request, cleared at deposit start
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ext_latch_q[c] <= 1'b0;
                blank_q        <= '0;
            end else if (active && st_q == ST_FETCH && biu_done) begin
                ext_latch_q[c] <= 1'b0; // R6 R8
                blank_q        <= 2'(dma_pkg::PIN_BLANK); // R7
            end else if (fall_en && blank_q != 2'h0) begin
                blank_q <= blank_q - 2'h1;
            end else if (fall_en) begin
                ext_latch_q[c] <= pin_lvl[c]; // R5
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                timer_pend_q[c] <= 1'b0;
            end else if (timer_max && ctrl_q[c][dma_pkg::B_ARM]) begin
                timer_pend_q[c] <= 1'b1; // R11
            end else if (take && grant_ch == c[0]) begin
                timer_pend_q[c] <= 1'b0; // R11
            end else if (!ctrl_q[c][dma_pkg::B_ARM]) begin
                timer_pend_q[c] <= 1'b0;
            end
        end

        always_comb begin
            if (!ctrl_q[c][dma_pkg::B_ARM] || ctrl_q[c][dma_pkg::B_SUSPEND]
                || nmi_block_q) begin
                req_ok[c] = 1'b0; // R4 R16 R17 R18
            end else if (ctrl_q[c][dma_pkg::B_TIMER_RQ]) begin
                req_ok[c] = timer_pend_q[c]; // R11
            end else if (sync == dma_pkg::SYNC_NONE) begin
                req_ok[c] = 1'b1; // R12
            end else begin
                req_ok[c] = ext_latch_q[c];
            end
        end

        // pointers, count, control
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                src_q[c]  <= '0;
                dst_q[c]  <= '0;
                cnt_q[c]  <= '0;
                ctrl_q[c] <= dma_pkg::CTRL_RESET;
            end else begin
                if (reg_wr && reg_addr == base + dma_pkg::OFF_SRC_LO) begin
                    src_q[c][15:0] <= reg_wdata;
                end else if (reg_wr && reg_addr == base + dma_pkg::OFF_SRC_HI) begin
                    src_q[c][19:16] <= reg_wdata[3:0]; // R1
                end else if (reg_wr && reg_addr == base + dma_pkg::OFF_DST_LO) begin
                    dst_q[c][15:0] <= reg_wdata;
                end else if (reg_wr && reg_addr == base + dma_pkg::OFF_DST_HI) begin
                    dst_q[c][19:16] <= reg_wdata[3:0]; // R1
                end else if (reg_wr && reg_addr == base + dma_pkg::OFF_COUNT) begin
                    cnt_q[c] <= reg_wdata; // R13
                end else if (reg_wr && reg_addr == base + dma_pkg::OFF_CTRL) begin
                    ctrl_q[c][15:2] <= reg_wdata[15:2];
                    ctrl_q[c][0]    <= reg_wdata[0];
                    if (reg_wdata[dma_pkg::B_CHANGE]) begin
                        ctrl_q[c][dma_pkg::B_ARM] <= reg_wdata[dma_pkg::B_ARM]; // R16
                    end
                end
                if (done_now) begin
                    cnt_q[c] <= cnt_q[c] - 16'h0001; // R13
                    if (ctrl_q[c][dma_pkg::B_SRC_INC] != ctrl_q[c][dma_pkg::B_SRC_DEC]) begin
                        src_q[c] <= ctrl_q[c][dma_pkg::B_SRC_INC] ? src_q[c] + step
                                                                  : src_q[c] - step; // R3
                    end
                    if (ctrl_q[c][dma_pkg::B_DST_INC] != ctrl_q[c][dma_pkg::B_DST_DEC]) begin
                        dst_q[c] <= ctrl_q[c][dma_pkg::B_DST_INC] ? dst_q[c] + step
                                                                  : dst_q[c] - step; // R3
                    end
                end
                if (stop_now) begin
                    ctrl_q[c][dma_pkg::B_ARM] <= 1'b0; // R14 R15
                end
            end
        end

        // terminal count flag, set wins over clear
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tc_hit_q[c] <= 1'b0;
            end else if (done_now && last) begin
                tc_hit_q[c] <= 1'b1;
            end else if (reg_wr && reg_addr == {1'b0, dma_pkg::OFF_STATUS}
                         && reg_wdata[c+1]) begin
                tc_hit_q[c] <= 1'b0;
            end
        end

        assign tc_irq[c] = tc_hit_q[c] & ctrl_q[c][dma_pkg::B_INT_EN]
                           & ctrl_q[c][dma_pkg::B_TERM_TC]; // R19
    end

    ////////////////////////////////////////
    // arbitration

    dma_arbiter u_arb (
        .clk         (clk),
        .rst_n       (rst_n),
        .req         (req_ok),
        .prio_hi     ({ctrl_q[1][dma_pkg::B_PRIO_HI], ctrl_q[0][dma_pkg::B_PRIO_HI]}),
        .take        (xfer_end),
        .done_ch     (ch_q),
        .bus_release (release_bus),
        .grant_ch    (grant_ch),
        .grant_valid (grant_valid)
    );

    assign take        = st_q == ST_IDLE && grant_valid && biu_gnt; // R20 R27
    assign xfer_end    = st_q == ST_DEPOSIT && biu_done;
    assign release_bus = st_q == ST_IDLE1 || (st_q == ST_IDLE && !grant_valid); // R10 R26

    ////////////////////////////////////////
    // transfer sequencer

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            ch_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (take) begin
                        st_q <= ST_FETCH;
                        ch_q <= grant_ch; // R27
                    end
                end
                ST_FETCH: begin
                    if (biu_done) begin
                        st_q <= ST_DEPOSIT; // R23
                    end
                end
                ST_DEPOSIT: begin
                    if (biu_done) begin
                        if (ctrl_q[ch_q][dma_pkg::B_SYNC_HI:dma_pkg::B_SYNC_LO]
                            == dma_pkg::SYNC_DST) begin
                            st_q <= ST_IDLE1; // R9
                        end else begin
                            st_q <= ST_IDLE; // R12
                        end
                    end
                end
                ST_IDLE1: begin
                    st_q <= ST_IDLE2; // R9
                end
                ST_IDLE2: begin
                    st_q <= ST_IDLE; // R9
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (st_q == ST_FETCH && biu_done) begin
            hold_q <= biu_rdata; // R23
        end
    end

    ////////////////////////////////////////
    // bus outputs

    always_comb begin
        if (st_q == ST_DEPOSIT) begin
            cur_addr = dst_q[ch_q];
            cur_io   = ~ctrl_q[ch_q][dma_pkg::B_DST_MEM];
        end else begin
            cur_addr = src_q[ch_q];
            cur_io   = ~ctrl_q[ch_q][dma_pkg::B_SRC_MEM];
        end
    end

    assign biu_req               = st_q == ST_IDLE && grant_valid; // R20
    assign bus_master_status_bit = st_q == ST_FETCH || st_q == ST_DEPOSIT; // R20
    assign biu_cmd.addr          = cur_addr; // R2
    assign biu_cmd.io_space      = cur_io;
    assign biu_cmd.word          = ctrl_q[ch_q][dma_pkg::B_WORD];
    assign biu_cmd.write         = st_q == ST_DEPOSIT;
    assign biu_wdata             = hold_q;
    assign cs_allow              = bus_master_status_bit
                                   && !(cur_io && cur_addr[19:16] != 4'h0); // R21

    ////////////////////////////////////////
    // register read

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == {1'b0, dma_pkg::OFF_STATUS}) begin
                reg_rdata <= {11'h000, st_q == ST_IDLE ? 1'b0 : 1'b1, ch_q,
                              tc_hit_q, nmi_block_q};
            end else if (reg_addr[2:0] == dma_pkg::OFF_SRC_LO[2:0]) begin
                reg_rdata <= src_q[reg_addr[3]][15:0];
            end else if (reg_addr[2:0] == dma_pkg::OFF_SRC_HI[2:0]) begin
                reg_rdata <= {12'h000, src_q[reg_addr[3]][19:16]};
            end else if (reg_addr[2:0] == dma_pkg::OFF_DST_LO[2:0]) begin
                reg_rdata <= dst_q[reg_addr[3]][15:0];
            end else if (reg_addr[2:0] == dma_pkg::OFF_DST_HI[2:0]) begin
                reg_rdata <= {12'h000, dst_q[reg_addr[3]][19:16]};
            end else if (reg_addr[2:0] == dma_pkg::OFF_COUNT[2:0]) begin
                reg_rdata <= cnt_q[reg_addr[3]];
            end else if (reg_addr[2:0] == dma_pkg::OFF_CTRL[2:0]) begin
                reg_rdata <= ctrl_q[reg_addr[3]];
            end else begin
                reg_rdata <= '0;
            end
        end
    end

endmodule

// *** dma_unit_monitor.sv ***
// port assertions for the dma unit
`timescale 1ns/100ps
module dma_unit_monitor (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // bus unit side
    input wire logic              biu_req,
    input wire logic              biu_gnt,
    input wire logic              biu_done,
    input wire dma_pkg::bus_req_t biu_cmd,
    input wire logic              bus_master_status_bit,
    input wire logic              cs_allow,
    input wire logic [15:0]       biu_rdata,
    input wire logic [15:0]       biu_wdata,
    // events
    input wire logic              nmi_active,
    input wire logic [1:0]        tc_irq
);
    logic on, fe, de;
    assign on = bus_master_status_bit;
    assign fe = on && !biu_cmd.write && biu_done;
    assign de = on && biu_cmd.write && biu_done;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    chk_single_owner: assert property (on |-> !biu_req)
        else $error("request in transfer");
    chk_grant_fetch: assert property (biu_req && biu_gnt |=> on && !biu_cmd.write)
        else $error("no fetch");
    chk_fetch_deposit: assert property (fe |=> on && biu_cmd.write)
        else $error("no deposit");
    chk_phase_stable: assert property (on && !biu_done |=> $stable(biu_cmd))
        else $error("command moved");
    chk_held_data: assert property (fe && biu_cmd.word |=> biu_wdata == $past(biu_rdata))
        else $error("data changed");
    chk_cs_high_io: assert property (on && biu_cmd.io_space && biu_cmd.addr[19:16] != 4'h0
        |-> !cs_allow)
        else $error("high io select");
    chk_irq_cause: assert property ($rose(|tc_irq) |-> $past(de))
        else $error("stray interrupt");
    chk_nmi_quiet: assert property (nmi_active [*3] |-> !biu_req)
        else $error("request during nmi");
    cover property (fe && biu_cmd.io_space);
    cover property (de ##1 biu_req);
    cover property ($rose(tc_irq[0]));
endmodule

bind dma_unit dma_unit_monitor dma_unit_monitor_i (.clk(clk), .rst_n(rst_n), .biu_req(biu_req),
    .biu_gnt(biu_gnt), .biu_done(biu_done), .biu_cmd(biu_cmd),
    .bus_master_status_bit(bus_master_status_bit), .cs_allow(cs_allow), .biu_rdata(biu_rdata),
    .biu_wdata(biu_wdata), .nmi_active(nmi_active), .tc_irq(tc_irq));

// *** biu_model.sv ***
// bus interface unit model answering fetch and deposit phases
`timescale 1ns/100ps
module biu_model (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // pacing
    input wire logic              slow,
    // dma side
    input wire logic              biu_req,
    input wire logic              bus_master_status_bit,
    input wire dma_pkg::bus_req_t biu_cmd,
    output logic                  biu_gnt,
    output logic                  biu_done,
    output logic [15:0]           biu_rdata
);
    logic [3:0]  cnt_q;
    logic        gnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            gnt_q <= 1'b0;
            biu_done <= 1'b0;
        end else begin
            gnt_q <= biu_req;
            biu_done <= bus_master_status_bit && !biu_done && cnt_q == (slow ? 4'h3 : 4'h0);
            cnt_q <= (biu_done || !bus_master_status_bit) ? 4'h0 : cnt_q + 4'h1;
        end
    end
    // slow mode grants a cycle late
    assign biu_gnt = !slow || gnt_q;
    assign biu_rdata = (bus_master_status_bit && !biu_cmd.write) ? biu_cmd.addr[15:0] ^ 16'h5a3c
                                                                 : ~biu_cmd.addr[15:0];
endmodule

// *** testbench.sv ***
// self-checking testbench for the two channel dma unit
`timescale 1ns/100ps
module testbench;
    logic              clk, rst_n, reg_wr, reg_rd, clock_output_pin, timer_max;
    logic              nmi_active, nmi_return, slow, biu_req, biu_gnt, biu_done, st, cs_allow;
    logic [4:0]        reg_addr;
    logic [15:0]       reg_wdata, reg_rdata, biu_rdata, biu_wdata, rv;
    logic [1:0]        pin, tc_irq;
    dma_pkg::bus_req_t biu_cmd;
    int                n_mismatch, n_tests, n_xfer;
    dma_unit dma_unit_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_request_pin(pin),
        .clock_output_pin(clock_output_pin), .timer_max(timer_max), .nmi_active(nmi_active),
        .nmi_return(nmi_return), .biu_req(biu_req), .biu_gnt(biu_gnt), .biu_done(biu_done),
        .biu_cmd(biu_cmd), .bus_master_status_bit(st), .cs_allow(cs_allow),
        .biu_rdata(biu_rdata), .biu_wdata(biu_wdata), .tc_irq(tc_irq));
    biu_model biu_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .biu_req(biu_req),
        .bus_master_status_bit(st), .biu_cmd(biu_cmd), .biu_gnt(biu_gnt),
        .biu_done(biu_done), .biu_rdata(biu_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) clock_output_pin <= ~clock_output_pin;
    always @(posedge clk) if (st && biu_cmd.write && biu_done) n_xfer <= n_xfer + 1;
    ////////////////////////////////////////
    task check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [4:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge clk);
    endtask
    task chk_ptr(input logic [4:0] a, input logic [19:0] exp);
        logic [15:0] lo;
        rd(a);
        lo = rv;
        rd(a + 5'h1);
        check({rv[3:0], lo}, exp);
    endtask
    task wait_xfer(input int n);
        int b;
        b = n_xfer;
        for (int i = 0; i < 400 && n_xfer != b + n; i++) begin
            @(posedge clk);
            #1;
        end
        if (n_xfer != b + n) begin
            n_mismatch++;
            end_sim();
        end
        repeat (20) @(posedge clk);
        #1 check(20'(n_xfer - b), 20'(n));
    endtask
    task tick();
        timer_max <= 1'b1;
        @(posedge clk);
        timer_max <= 1'b0;
        wait_xfer(1);
    endtask
    ////////////////////////////////////////
    task t_unarmed();
        rd(5'h07);
        check(20'(rv), 20'h0);
        wr(5'h04, 16'h0003);
        wr(5'h05, 16'hd700);
        pin[0] <= 1'b1;
        wait_xfer(0);
        pin[0] <= 1'b0;
        rd(5'h04);
        check(20'(rv), 20'h3);
    endtask
    task t_unsync();
        wr(5'h00, 16'h1234);
        wr(5'h01, 16'h000a);
        wr(5'h02, 16'hfedc);
        wr(5'h03, 16'h0005);
        chk_ptr(5'h00, 20'ha1234);
        wr(5'h05, 16'hd706);
        wait_xfer(3);
        chk_ptr(5'h00, 20'ha1237);
        chk_ptr(5'h02, 20'h5fed9);
        rd(5'h04);
        check(20'(rv), 20'h0);
        check(20'(tc_irq), 20'h1);
        wr(5'h06, 16'h0006);
        check(20'(tc_irq), 20'h0);
    endtask
    task t_word_io();
        slow <= 1'b1;
        wr(5'h08, 16'h0010);
        wr(5'h09, 16'h0003);
        wr(5'h0a, 16'h0200);
        wr(5'h0c, 16'h0002);
        wr(5'h0d, 16'ha407);
        wait_xfer(2);
        slow <= 1'b0;
        chk_ptr(5'h08, 20'h30014);
        chk_ptr(5'h0a, 20'h00204);
    endtask
    task t_timer();
        wr(5'h0c, 16'h0005);
        wr(5'h0d, 16'h9056);
        wait_xfer(0);
        tick();
        tick();
        rd(5'h0c);
        check(20'(rv), 20'h3);
        wr(5'h0d, 16'h0004);
        timer_max <= 1'b1;
        @(posedge clk);
        timer_max <= 1'b0;
        wait_xfer(0);
    endtask
    task t_nmi();
        nmi_active <= 1'b1;
        wr(5'h04, 16'h0002);
        wr(5'h05, 16'hd706);
        wait_xfer(0);
        nmi_active <= 1'b0;
        nmi_return <= 1'b1;
        @(posedge clk);
        nmi_return <= 1'b0;
        wait_xfer(2);
        wr(5'h06, 16'h0006);
    endtask
    task t_pin();
        wr(5'h04, 16'h0004);
        wr(5'h05, 16'h9046);
        pin[0] <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(20'(biu_req), 20'h0);
        for (int i = 0; i < 200 && !(st && biu_cmd.write); i++) begin
            @(posedge clk);
            #1;
        end
        pin[0] <= 1'b0;
        wait_xfer(1);
        rd(5'h04);
        check(20'(rv), 20'h3);
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, clock_output_pin, timer_max, nmi_active, nmi_return, slow} = '0;
        {reg_addr, reg_wdata, pin} = '0;
        {n_mismatch, n_tests, n_xfer} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_unarmed();
        t_unsync();
        t_word_io();
        t_timer();
        t_nmi();
        t_pin();
        end_sim();
    end
endmodule
